//--- common/vbc_pkg.sv
// Constants and types for band calibration control
package vbc_pkg;
    // Register offsets
    localparam logic [5:0] OFF_INT = 6'h03;
    localparam logic [5:0] OFF_FRAC = 6'h04;
    localparam logic [5:0] OFF_LINK = 6'h05;
    localparam logic [5:0] OFF_MODE = 6'h06;
    localparam logic [5:0] OFF_LOCK_CFG = 6'h07;
    localparam logic [5:0] OFF_CAL_CFG = 6'h0A;
    localparam logic [5:0] OFF_READBACK = 6'h10;

    // Field positions
    localparam int unsigned FRAC_MODE_BIT = 11;
    localparam int unsigned RELOCK_EN_BIT = 13;
    localparam int unsigned CAL_DIS_BIT = 11;
    localparam int unsigned CLK_SEL_LSB = 13;
    localparam int unsigned MEAS_EXP_LSB = 0;
    localparam int unsigned WAIT_K_LSB = 6;

    // Values after reset
    localparam logic [23:0] RST_INT = 24'h00_0000;
    localparam logic [23:0] RST_FRAC = 24'h00_0000;
    localparam logic [23:0] RST_LINK = 24'h00_0000;
    localparam logic [23:0] RST_MODE = 24'h00_0000;
    localparam logic [23:0] RST_LOCK_CFG = 24'h00_0000;
    localparam logic [23:0] RST_CAL_CFG = 24'h00_0000;
    localparam logic [7:0] RST_SWITCH = 8'h00;

    // Link word: id [2:0], register [6:3], data [15:7]
    localparam int unsigned LINK_BITS = 16;
    localparam int unsigned LINK_ADDR_LSB = 3;
    localparam int unsigned LINK_DATA_LSB = 7;
    localparam int unsigned SW_W = 8;
    localparam logic [3:0] SUB_REG_DIVIDER = 4'h2;
    localparam logic [3:0] SUB_REG_CONFIG = 4'h3;
    localparam logic [5:0] RST_DIV_RATIO = 6'h01;

    // Serial clock ratio per select code
    localparam logic [5:0] CLK_RATIO_0 = 6'h01;
    localparam logic [5:0] CLK_RATIO_1 = 6'h04;
    localparam logic [5:0] CLK_RATIO_2 = 6'h10;
    localparam logic [5:0] CLK_RATIO_3 = 6'h20;

    // Wait unit in ticks
    localparam logic [8:0] WAIT_UNIT = 9'h064;

    typedef enum logic [1:0] {
        VBC_FUNDAMENTAL,
        VBC_DIVIDED,
        VBC_DOUBLED
    } vbc_out_mode_t;
endpackage

//--- rtl/vbc_cal_ctrl.sv
// Band calibration control: registers, search and link
//
// How it works
// - Three output modes.
// - Calibration picks sub-band.
// - Host may drive switches via link.
// - Hold mid-point, measure, search.
// - One pass per request.
// - Calibration keeps link address.
// - Recalibrate once on unlock.
// - Chosen switches readable.
// - Manual link writes wait for a running calibration.
// - Disabled: link writes forwarded at once.
// - Link: sixteen serial clocks.
// - Serial clock is reference over 1/4/16/32.
// - Fraction write in fractional mode: calibrate, load modulator.
// - Disabled: fraction loads at once.
// - Integer write in integer mode: calibrate, load prescaler.
// - Disabled: integer loads at once.
// - Same-value rewrite recalibrates.
`timescale 1ns/100ps
module vbc_cal_ctrl (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_reg_wr_en,
    input wire logic i_reg_rd_en,
    input wire logic [5:0] i_reg_addr,
    input wire logic [23:0] i_reg_wdata,
    output logic [23:0] o_reg_rdata,
    input wire logic i_lock_detect,
    input wire logic i_meas_done,
    input wire logic [31:0] i_meas_count,
    output logic o_meas_start,
    output logic [2:0] o_meas_exp,
    output logic o_tune_hold_mid,
    output logic o_cal_busy,
    output logic [23:0] o_prescaler_int,
    output logic [23:0] o_modulator_frac,
    output logic o_freq_load,
    output logic o_link_sck,
    output logic o_link_sdo,
    output logic o_link_frame,
    output logic [1:0] o_out_mode,
    output logic [5:0] o_out_div_ratio
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CAL_SEND,
        ST_CAL_WAIT,
        ST_CAL_MEAS,
        ST_CAL_FINAL,
        ST_CAL_LOAD,
        ST_HOST_SEND
    } vbc_state_t;

    vbc_state_t state_q;

    logic [23:0] int_q;
    logic [23:0] frac_q;
    logic [23:0] link_q;
    logic [23:0] mode_q;
    logic [23:0] lock_cfg_q;
    logic [23:0] cal_cfg_q;
    logic [7:0] readback_q;
    logic [7:0] sw_q;
    logic [2:0] idx_q;
    logic [8:0] wait_q;
    logic cal_req_q;
    logic host_link_q;
    logic retry_used_q;
    logic armed_q;
    logic lock_meta_q;
    logic lock_sync_q;
    logic lock_prev_q;
    logic link_start_q;
    logic [15:0] link_word_q;
    logic [5:0] div_ratio_q;
    logic doubler_q;

    logic tick;
    logic link_busy;
    logic link_done;
    logic cal_dis;
    logic frac_mode;
    logic wr_int;
    logic wr_frac;
    logic wr_link;
    logic freq_trigger;
    logic lock_lost;
    logic relock_go;
    logic [7:0] trial;
    logic [7:0] kept;
    logic [47:0] n_full;
    logic [55:0] n_scaled;
    logic [31:0] target;

    // Switch into data field, address and id kept
    function automatic logic [15:0] with_switch(input logic [23:0] word, input logic [7:0] sw);
        logic [15:0] w;
        w = word[15:0];
        w[vbc_pkg::LINK_DATA_LSB +: vbc_pkg::SW_W] = sw;
        return w;
    endfunction

    assign cal_dis = cal_cfg_q[vbc_pkg::CAL_DIS_BIT];
    assign frac_mode = mode_q[vbc_pkg::FRAC_MODE_BIT];
    assign wr_int = i_reg_wr_en && (i_reg_addr == vbc_pkg::OFF_INT);
    assign wr_frac = i_reg_wr_en && (i_reg_addr == vbc_pkg::OFF_FRAC);
    assign wr_link = i_reg_wr_en && (i_reg_addr == vbc_pkg::OFF_LINK);
    // Rewrites trigger too
    assign freq_trigger = !cal_dis && ((wr_frac && frac_mode) || (wr_int && !frac_mode));
    assign lock_lost = lock_prev_q && !lock_sync_q;
    assign relock_go = lock_cfg_q[vbc_pkg::RELOCK_EN_BIT] && lock_lost && armed_q && !retry_used_q
        && !cal_dis;
    assign trial = sw_q | (8'h01 << idx_q);
    // More capacitance, lower frequency: keep the bit while the count is high
    assign kept = (i_meas_count > target) ? trial : sw_q;
    assign o_meas_exp = cal_cfg_q[vbc_pkg::MEAS_EXP_LSB +: 3];

    // Target count: floor(N * 2^n)
    assign n_full = {int_q, frac_q};
    assign n_scaled = {8'h00, n_full} << o_meas_exp;
    assign target = n_scaled[55:24];

    vbc_tick_div u_tick_div (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_sel(cal_cfg_q[vbc_pkg::CLK_SEL_LSB +: 2]),
        .o_tick(tick)
    );

    vbc_link_ser u_link_ser (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_tick(tick),
        .i_start(link_start_q),
        .i_word(link_word_q),
        .o_busy(link_busy),
        .o_done(link_done),
        .o_sck(o_link_sck),
        .o_sdo(o_link_sdo)
    );

    assign o_link_frame = link_busy;

    // Lock detect is asynchronous: two flops first
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            lock_meta_q <= 1'b0;
            lock_sync_q <= 1'b0;
            lock_prev_q <= 1'b0;
        end else begin
            lock_meta_q <= i_lock_detect;
            lock_sync_q <= lock_meta_q;
            lock_prev_q <= lock_sync_q;
        end
    end

    // Host register writes
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            int_q <= vbc_pkg::RST_INT;
            frac_q <= vbc_pkg::RST_FRAC;
            link_q <= vbc_pkg::RST_LINK;
            mode_q <= vbc_pkg::RST_MODE;
            lock_cfg_q <= vbc_pkg::RST_LOCK_CFG;
            cal_cfg_q <= vbc_pkg::RST_CAL_CFG;
        end else if (i_reg_wr_en) begin
            case (i_reg_addr)
                vbc_pkg::OFF_INT: int_q <= i_reg_wdata;
                vbc_pkg::OFF_FRAC: frac_q <= i_reg_wdata;
                vbc_pkg::OFF_LINK: link_q <= i_reg_wdata;
                vbc_pkg::OFF_MODE: mode_q <= i_reg_wdata;
                vbc_pkg::OFF_LOCK_CFG: lock_cfg_q <= i_reg_wdata;
                vbc_pkg::OFF_CAL_CFG: cal_cfg_q <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // Register reads
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_reg_rdata <= 24'h00_0000;
        end else if (i_reg_rd_en) begin
            case (i_reg_addr)
                vbc_pkg::OFF_INT: o_reg_rdata <= int_q;
                vbc_pkg::OFF_FRAC: o_reg_rdata <= frac_q;
                vbc_pkg::OFF_LINK: o_reg_rdata <= link_q;
                vbc_pkg::OFF_MODE: o_reg_rdata <= mode_q;
                vbc_pkg::OFF_LOCK_CFG: o_reg_rdata <= lock_cfg_q;
                vbc_pkg::OFF_CAL_CFG: o_reg_rdata <= cal_cfg_q;
                vbc_pkg::OFF_READBACK: o_reg_rdata <= {16'h0000, readback_q};
                default: o_reg_rdata <= 24'h00_0000;
            endcase
        end
    end

    // Pending requests; a new request beats the clear
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cal_req_q <= 1'b0;
            host_link_q <= 1'b0;
        end else begin
            if (freq_trigger || relock_go) begin
                cal_req_q <= 1'b1;
            end else if (state_q == ST_IDLE) begin
                cal_req_q <= 1'b0;
            end
            if (wr_link) begin
                host_link_q <= 1'b1;
            end else if (state_q == ST_IDLE && !cal_req_q) begin
                host_link_q <= 1'b0;
            end
        end
    end

    // One retry per request
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            retry_used_q <= 1'b0;
        end else if (freq_trigger) begin
            retry_used_q <= 1'b0;
        end else if (relock_go) begin
            retry_used_q <= 1'b1;
        end
    end

    // Calibration and link sequencing
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            sw_q <= vbc_pkg::RST_SWITCH;
            idx_q <= 3'd7;
            wait_q <= 9'h000;
            link_start_q <= 1'b0;
            link_word_q <= 16'h0000;
            o_meas_start <= 1'b0;
            readback_q <= vbc_pkg::RST_SWITCH;
            armed_q <= 1'b0;
        end else begin
            link_start_q <= 1'b0;
            o_meas_start <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (cal_req_q) begin
                        sw_q <= vbc_pkg::RST_SWITCH;
                        idx_q <= 3'd7;
                        armed_q <= 1'b0;
                        link_word_q <= with_switch(link_q, 8'h80);
                        link_start_q <= 1'b1;
                        state_q <= ST_CAL_SEND;
                    end else if (host_link_q) begin
                        link_word_q <= link_q[15:0];
                        link_start_q <= 1'b1;
                        state_q <= ST_HOST_SEND;
                    end
                end
                ST_CAL_SEND: begin
                    if (link_done) begin
                        wait_q <= 9'(cal_cfg_q[vbc_pkg::WAIT_K_LSB +: 2] * vbc_pkg::WAIT_UNIT);
                        state_q <= ST_CAL_WAIT;
                    end
                end
                ST_CAL_WAIT: begin
                    if (wait_q == 9'h000) begin
                        o_meas_start <= 1'b1;
                        state_q <= ST_CAL_MEAS;
                    end else if (tick) begin
                        wait_q <= wait_q - 9'h001;
                    end
                end
                ST_CAL_MEAS: begin
                    if (i_meas_done) begin
                        sw_q <= kept;
                        link_start_q <= 1'b1;
                        if (idx_q == 3'd0) begin
                            link_word_q <= with_switch(link_q, kept);
                            state_q <= ST_CAL_FINAL;
                        end else begin
                            idx_q <= idx_q - 3'd1;
                            link_word_q <= with_switch(link_q, kept | (8'h01 << (idx_q - 3'd1)));
                            state_q <= ST_CAL_SEND;
                        end
                    end
                end
                ST_CAL_FINAL: begin
                    if (link_done) begin
                        state_q <= ST_CAL_LOAD;
                    end
                end
                ST_CAL_LOAD: begin
                    readback_q <= sw_q;
                    armed_q <= 1'b1;
                    state_q <= ST_IDLE;
                end
                ST_HOST_SEND: begin
                    if (link_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign o_cal_busy = (state_q != ST_IDLE) && (state_q != ST_HOST_SEND);
    assign o_tune_hold_mid = o_cal_busy;

    // Prescaler and modulator words
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_prescaler_int <= vbc_pkg::RST_INT;
            o_modulator_frac <= vbc_pkg::RST_FRAC;
            o_freq_load <= 1'b0;
        end else begin
            o_freq_load <= 1'b0;
            if (state_q == ST_CAL_LOAD) begin
                o_prescaler_int <= int_q;
                o_modulator_frac <= frac_q;
                o_freq_load <= 1'b1;
            end else if (cal_dis && wr_int) begin
                o_prescaler_int <= i_reg_wdata;
                o_freq_load <= 1'b1;
            end else if (cal_dis && wr_frac) begin
                o_modulator_frac <= i_reg_wdata;
                o_freq_load <= 1'b1;
            end
        end
    end

    // Output mode tracks divider and config words sent
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            div_ratio_q <= vbc_pkg::RST_DIV_RATIO;
            doubler_q <= 1'b0;
        end else if (link_done) begin
            if (link_word_q[vbc_pkg::LINK_ADDR_LSB +: 4] == vbc_pkg::SUB_REG_DIVIDER) begin
                // Odd ratios above one round down
                if (link_word_q[vbc_pkg::LINK_DATA_LSB +: 6] > 6'h01) begin
                    div_ratio_q <= {link_word_q[vbc_pkg::LINK_DATA_LSB + 1 +: 5], 1'b0};
                end else begin
                    div_ratio_q <= vbc_pkg::RST_DIV_RATIO;
                end
            end else if (link_word_q[vbc_pkg::LINK_ADDR_LSB +: 4] == vbc_pkg::SUB_REG_CONFIG) begin
                doubler_q <= link_word_q[vbc_pkg::LINK_DATA_LSB];
            end
        end
    end

    always_comb begin
        if (doubler_q) begin
            o_out_mode = vbc_pkg::VBC_DOUBLED;
        end else if (div_ratio_q != vbc_pkg::RST_DIV_RATIO) begin
            o_out_mode = vbc_pkg::VBC_DIVIDED;
        end else begin
            o_out_mode = vbc_pkg::VBC_FUNDAMENTAL;
        end
    end

    assign o_out_div_ratio = div_ratio_q;
endmodule

//--- rtl/vbc_link_ser.sv
// Shifts a 16-bit word out, one bit per tick
`timescale 1ns/100ps
module vbc_link_ser (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_tick,
    input wire logic i_start,
    input wire logic [15:0] i_word,
    output logic o_busy,
    output logic o_done,
    output logic o_sck,
    output logic o_sdo
);
    logic [15:0] shift_q;
    logic [3:0] cnt_q;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            shift_q <= 16'h0000;
            cnt_q <= 4'h0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !o_busy) begin
                shift_q <= i_word;
                cnt_q <= 4'h0;
                o_busy <= 1'b1;
            end else if (o_busy && i_tick) begin
                shift_q <= {shift_q[14:0], 1'b0};
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == 4'hF) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end

    assign o_sdo = shift_q[15];
    assign o_sck = o_busy & i_tick;
endmodule

//--- rtl/vbc_tick_div.sv
// Divides the reference clock into tick pulses
`timescale 1ns/100ps
module vbc_tick_div (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [1:0] i_sel,
    output logic o_tick
);
    logic [5:0] ratio;
    logic [5:0] cnt_q;

    always_comb begin
        case (i_sel)
            2'd0: ratio = vbc_pkg::CLK_RATIO_0;
            2'd1: ratio = vbc_pkg::CLK_RATIO_1;
            2'd2: ratio = vbc_pkg::CLK_RATIO_2;
            default: ratio = vbc_pkg::CLK_RATIO_3;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cnt_q <= 6'h00;
            o_tick <= 1'b0;
        end else if (cnt_q >= ratio - 6'h01) begin
            cnt_q <= 6'h00;
            o_tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 6'h01;
            o_tick <= 1'b0;
        end
    end
endmodule

//--- verification/vbc_cal_ctrl_assertions.sv
// Port-level checks for band calibration control
`timescale 1ns/100ps
module vbc_cal_ctrl_chk (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_reg_wr_en,
    input wire logic i_reg_rd_en,
    input wire logic [5:0] i_reg_addr,
    input wire logic [23:0] i_reg_wdata,
    input wire logic [23:0] o_reg_rdata,
    input wire logic o_tune_hold_mid,
    input wire logic o_cal_busy,
    input wire logic [23:0] o_prescaler_int,
    input wire logic [23:0] o_modulator_frac,
    input wire logic o_freq_load,
    input wire logic o_link_sck,
    input wire logic o_link_frame
);
    logic dis_q;
    logic frac_q;
    logic [4:0] bits_q;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            dis_q <= 1'b0;
            frac_q <= 1'b0;
        end else if (i_reg_wr_en) begin
            if (i_reg_addr == vbc_pkg::OFF_CAL_CFG) dis_q <= i_reg_wdata[vbc_pkg::CAL_DIS_BIT];
            if (i_reg_addr == vbc_pkg::OFF_MODE) frac_q <= i_reg_wdata[vbc_pkg::FRAC_MODE_BIT];
        end
    end
    // Bits in current frame
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !o_link_frame) begin
            bits_q <= 5'h00;
        end else if (o_link_sck) begin
            bits_q <= bits_q + 5'h01;
        end
    end
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_cal_wr;
        i_reg_wr_en && !dis_q && i_reg_addr == (frac_q ? vbc_pkg::OFF_FRAC : vbc_pkg::OFF_INT);
    endsequence
    sequence s_link_wr;
        i_reg_wr_en && dis_q && i_reg_addr == vbc_pkg::OFF_LINK && !o_link_frame && !o_cal_busy;
    endsequence
    chk_hold_mid:
        assert property (o_tune_hold_mid == o_cal_busy)
        else $error("hold not busy");
    chk_int_direct:
        assert property (i_reg_wr_en && dis_q && i_reg_addr == vbc_pkg::OFF_INT |=> o_freq_load && o_prescaler_int == $past(i_reg_wdata))
        else $error("int not loaded");
    chk_frac_direct:
        assert property (i_reg_wr_en && dis_q && i_reg_addr == vbc_pkg::OFF_FRAC |=> o_freq_load && o_modulator_frac == $past(i_reg_wdata))
        else $error("frac not loaded");
    chk_cal_start:
        assert property (s_cal_wr |-> ##[1:4] o_cal_busy)
        else $error("no calibration");
    chk_words_frozen:
        assert property (o_cal_busy && $past(o_cal_busy) |-> $stable(o_prescaler_int) && $stable(o_modulator_frac))
        else $error("words moved in cal");
    chk_load_pulse:
        assert property ($changed(o_prescaler_int) || $changed(o_modulator_frac) |-> o_freq_load)
        else $error("no load pulse");
    chk_link_start:
        assert property (s_link_wr |-> ##[1:3] o_link_frame)
        else $error("no link frame");
    chk_sixteen_bits:
        assert property ($fell(o_link_frame) |-> bits_q == 5'h10)
        else $error("bit count");
    chk_readback_hi:
        assert property (i_reg_rd_en && i_reg_addr == vbc_pkg::OFF_READBACK |=> o_reg_rdata[23:8] == 16'h0000)
        else $error("readback high bits");
endmodule
bind vbc_cal_ctrl vbc_cal_ctrl_chk chk_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_wr_en(i_reg_wr_en),
    .i_reg_rd_en(i_reg_rd_en), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_tune_hold_mid(o_tune_hold_mid), .o_cal_busy(o_cal_busy), .o_prescaler_int(o_prescaler_int),
    .o_modulator_frac(o_modulator_frac), .o_freq_load(o_freq_load), .o_link_sck(o_link_sck),
    .o_link_frame(o_link_frame));

//--- verification/vbc_cal_ctrl_bench.sv
// Self-checking bench for the band calibration control block
`timescale 1ns/100ps
module vbc_cal_ctrl_bench;
    localparam logic [31:0] BASE = 32'h0000_03E8;
    localparam logic [23:0] LINK_W = 24'h00_8041;
    logic clk, rst, we, re, lk, md, ms, busy, hold, fl, sck, sdo, frm, slow;
    logic [5:0] ad, oratio, gap;
    logic [23:0] wd, rdat, pint, pfr, q;
    logic [31:0] mc;
    logic [2:0] mexp;
    logic [1:0] omode;
    logic [15:0] word;
    logic [4:0] nbits;
    logic [7:0] nmeas, m0;
    logic [5:0] ratio [4] = '{vbc_pkg::CLK_RATIO_0, vbc_pkg::CLK_RATIO_1, vbc_pkg::CLK_RATIO_2, vbc_pkg::CLK_RATIO_3};
    logic [15:0] mw [5] = '{16'h1F10, 16'h0390, 16'h0090, 16'h0098, 16'h0018};
    logic [5:0] mr [5] = '{6'h3E, 6'h06, 6'h01, 6'h01, 6'h01};
    vbc_pkg::vbc_out_mode_t mm [5] = '{vbc_pkg::VBC_DIVIDED, vbc_pkg::VBC_DIVIDED, vbc_pkg::VBC_FUNDAMENTAL,
        vbc_pkg::VBC_DOUBLED, vbc_pkg::VBC_FUNDAMENTAL};
    int errors = 0;
    int n_tests = 0;
    int n_loads = 0;
    int l0;
    vbc_cal_ctrl uut (.i_core_clk(clk), .i_rst(rst), .i_reg_wr_en(we), .i_reg_rd_en(re), .i_reg_addr(ad),
        .i_reg_wdata(wd), .o_reg_rdata(rdat), .i_lock_detect(lk), .i_meas_done(md), .i_meas_count(mc),
        .o_meas_start(ms), .o_meas_exp(mexp), .o_tune_hold_mid(hold), .o_cal_busy(busy), .o_prescaler_int(pint),
        .o_modulator_frac(pfr), .o_freq_load(fl), .o_link_sck(sck), .o_link_sdo(sdo), .o_link_frame(frm),
        .o_out_mode(omode), .o_out_div_ratio(oratio));
    vbc_osc_model #(.BASE_COUNT(BASE)) osc (.i_core_clk(clk), .i_rst(rst), .i_slow(slow), .i_sck(sck), .i_sdo(sdo),
        .i_frame(frm), .i_meas_start(ms), .o_meas_done(md), .o_meas_count(mc), .o_word(word), .o_bits(nbits),
        .o_gap(gap), .o_n_meas(nmeas));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (fl === 1'b1) n_loads++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        @(posedge clk);
        we <= 1'b1;
        ad <= a;
        wd <= d;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [23:0] d);
        @(posedge clk);
        re <= 1'b1;
        ad <= a;
        @(posedge clk);
        re <= 1'b0;
        #1 d = rdat;
    endtask
    task automatic wait_idle();
        int i;
        repeat (8) @(posedge clk);
        for (i = 0; i < 4000 && (busy !== 1'b0 || frm !== 1'b0); i++) @(posedge clk);
        check(i < 4000, 1'b1, "idle timeout");
        #1;
    endtask
    // Largest switch whose count stays above target
    function automatic logic [7:0] exp_sw(input logic [23:0] v);
        return 8'(BASE - {8'h00, v} - 32'h0000_0001);
    endfunction
    task automatic verify(input logic [7:0] sw);
        check(nmeas - m0, 8'h08, "meas count");
        check(n_loads - l0, 32'h0000_0001, "loads");
        check(word, {LINK_W[15], sw, LINK_W[6:0]}, "link word");
        rd(vbc_pkg::OFF_READBACK, q);
        check(q, {16'h0000, sw}, "readback");
    endtask
    task automatic cal_int(input logic [23:0] v);
        m0 = nmeas;
        l0 = n_loads;
        wr(vbc_pkg::OFF_INT, v);
        wait_idle();
        check(pint, v, "prescaler");
        verify(exp_sw(v));
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        {rst, we, re, lk, slow, ad, wd} = '0;
        rst = 1'b1;
        lk = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wr(vbc_pkg::OFF_LINK, LINK_W);
        wait_idle();
        cal_int(24'h00_0384);
        slow <= 1'b1;
        cal_int(24'h00_0384);
        slow <= 1'b0;
        rd(vbc_pkg::OFF_INT, q);
        check(q, 24'h00_0384, "int read");
        rd(6'h3F, q);
        check(q, 24'h00_0000, "unmapped read");
        wr(vbc_pkg::OFF_READBACK, 24'hFF_FFFF);
        rd(vbc_pkg::OFF_READBACK, q);
        check(q, 24'h00_0063, "readback RO");
        $display("integer test done");
        wr(vbc_pkg::OFF_MODE, 24'h00_0800);
        wr(vbc_pkg::OFF_INT, 24'h00_03B6);
        repeat (8) @(posedge clk);
        #1 check(busy, 1'b0, "int write, frac mode");
        m0 = nmeas;
        l0 = n_loads;
        wr(vbc_pkg::OFF_FRAC, 24'h80_0000);
        repeat (3) @(posedge clk);
        #1 check(pfr, 24'h00_0000, "early modulator");
        wait_idle();
        check(pfr, 24'h80_0000, "modulator");
        check(pint, 24'h00_03B6, "stored int");
        verify(exp_sw(24'h00_03B6));
        $display("fraction test done");
        wr(vbc_pkg::OFF_CAL_CFG, 24'h00_0800);
        m0 = nmeas;
        wr(vbc_pkg::OFF_FRAC, 24'h12_3456);
        @(posedge clk);
        #1 check(pfr, 24'h12_3456, "direct frac");
        wr(vbc_pkg::OFF_MODE, 24'h00_0000);
        wr(vbc_pkg::OFF_INT, 24'h00_0123);
        @(posedge clk);
        #1 check(pint, 24'h00_0123, "direct int");
        check(nmeas, m0, "no measure");
        for (int s = 0; s < 4; s++) begin
            wr(vbc_pkg::OFF_CAL_CFG, 24'h00_0800 | (24'(s) << vbc_pkg::CLK_SEL_LSB) | 24'(s));
            wr(vbc_pkg::OFF_LINK, 24'h00_A5C0 + 24'(s));
            wait_idle();
            check(word, 16'hA5C0 + 16'(s), "manual word");
            check(nbits, 5'h10, "bits");
            check(gap, ratio[s], "clock ratio");
            check(mexp, s, "exponent");
        end
        wr(vbc_pkg::OFF_CAL_CFG, 24'h00_0800);
        for (int i = 0; i < 5; i++) begin
            wr(vbc_pkg::OFF_LINK, {8'h00, mw[i]});
            wait_idle();
            check(oratio, mr[i], "div ratio");
            check(omode, mm[i], "mode");
        end
        $display("manual test done");
        wr(vbc_pkg::OFF_CAL_CFG, 24'h00_0000);
        wr(vbc_pkg::OFF_LINK, LINK_W);
        wait_idle();
        wr(vbc_pkg::OFF_LOCK_CFG, 24'h00_2000);
        cal_int(24'h00_0384);
        m0 = nmeas;
        lk <= 1'b0;
        wait_idle();
        check(nmeas - m0, 8'h08, "relock");
        lk <= 1'b1;
        repeat (8) @(posedge clk);
        lk <= 1'b0;
        wait_idle();
        check(nmeas - m0, 8'h08, "single relock");
        $display("test relock done");
        end_sim();
    end
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule

//--- verification/vbc_osc_model.sv
// Oscillator stand-in: takes link words, returns counts
`timescale 1ns/100ps
module vbc_osc_model #(
    parameter logic [31:0] BASE_COUNT = 32'h0000_03E8
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_slow,
    input wire logic i_sck,
    input wire logic i_sdo,
    input wire logic i_frame,
    input wire logic i_meas_start,
    output logic o_meas_done,
    output logic [31:0] o_meas_count,
    output logic [15:0] o_word,
    output logic [4:0] o_bits,
    output logic [5:0] o_gap,
    output logic [7:0] o_n_meas
);
    logic [15:0] sh_q;
    logic frame_q;
    logic busy_q;
    logic [5:0] run_q;
    logic [5:0] wait_q;
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            {sh_q, frame_q, busy_q, run_q, wait_q, o_meas_done, o_word, o_bits, o_gap, o_n_meas} <= '0;
            o_meas_count <= 32'h0000_0000;
        end else begin
            frame_q <= i_frame;
            o_meas_done <= 1'b0;
            if (i_sck && i_frame) begin
                sh_q <= {sh_q[14:0], i_sdo};
                o_bits <= (frame_q ? o_bits : 5'h00) + 5'h01;
                o_gap <= run_q;
                run_q <= 6'h01;
            end else if (run_q != 6'h3F) begin
                run_q <= run_q + 6'h01;
            end
            if (i_frame && !frame_q && !i_sck) o_bits <= 5'h00;
            if (!i_frame && frame_q) begin
                o_word <= sh_q;
            end
            // A higher switch setting gives a lower count
            if (i_meas_start) begin
                busy_q <= 1'b1;
                wait_q <= i_slow ? 6'h14 : 6'h01;
                o_n_meas <= o_n_meas + 8'h01;
            end else if (busy_q && wait_q == 6'h00) begin
                busy_q <= 1'b0;
                o_meas_done <= 1'b1;
                o_meas_count <= BASE_COUNT - {24'h00_0000, o_word[14:7]};
            end else if (busy_q) begin
                wait_q <= wait_q - 6'h01;
            end else begin
                o_meas_count <= ~o_meas_count;
            end
        end
    end
endmodule
